/* design/cud_user_data.sv */
// User data memory of the controller: word and bit views, I/O refresh, timers.
// Assumes module pins and straps are asynchronous; peripheral memory and
// fault pulses come from logic on sys_clk.
`timescale 1ns/100ps
module cud_user_data #(
  parameter int TICK_CYCLES = cud_pkg::FAST_TICK_CYC
) (
  // Clock and reset
  input logic sys_clk,
  input logic rst,
  // Processor register port
  input cud_pkg::cud_addr_type regAddr,
  input logic [15:0] regWrData,
  input logic regWr,
  input logic regRd,
  output logic [15:0] regRdData,
  // I/O module pins
  input logic [cud_pkg::IO_WORDS-1:0][15:0] modIn,
  output logic [cud_pkg::IO_WORDS-1:0][15:0] modOut,
  // Peripheral memory for the initial load
  input logic perMemPresent,
  input logic [15:0] perMemData,
  output logic [11:0] perMemAddr,
  output logic perMemRd,
  // Straps, faults and state
  input cud_pkg::cud_retain_type retainCfg,
  input logic protectRun,
  input logic [15:0] faultIn,
  output logic initDone
);
  import cud_pkg::*;

  logic [IO_WORDS-1:0][15:0] modInMeta;
  logic [IO_WORDS-1:0][15:0] modInSync;
  logic [IO_WORDS-1:0][15:0] inReg;
  logic [IO_WORDS-1:0][15:0] outReg;
  logic [IO_WORDS-1:0] directOnly;
  logic protMeta, protSync, perMeta, perSync;
  cud_retain_type retMeta, retSync;
  logic [15:0] ram [0:RAM_WORDS-1];
  logic [15:0] idxReg [0:2];
  logic [TIMERS-1:0] timerRun, timerBit, counterBit;
  logic [15:0] faultReg, pulseWord, calSec;
  cud_state_type state;
  logic [14:0] initPtr;
  logic [12:0] loadPtr;
  logic loadRdQ;
  logic [11:0] loadAddrQ;
  logic [31:0] tickCnt;
  logic [3:0] slowCnt, secCnt;
  logic fastTick, slowTick, secTick;
  logic sweepBusy;
  logic [8:0] sweepPtr, sweepEnd;
  logic [12:0] effWord;
  logic [7:0] w8;
  logic [14:0] ramAddr;
  logic isRam, rdOk, wrOk, procRamWr, ctlWr, sweepStep, clrEn;
  logic [15:0] curWord, wrVal, rdVal, tmrCur;

  // Legal word range and bit access per view
  function automatic logic accessOk(input cud_area_type a, input logic [12:0] w,
                                    input logic b, input logic isWrite);
    logic ok;
    ok = 1'b0;
    case (a)
      AR_IN, AR_DIN: ok = (int'(w) < IO_WORDS) && !isWrite; // [RULE_02] [RULE_06]
      AR_OUT, AR_DOUT, AR_SPC, AR_RLK: ok = int'(w) < IO_WORDS; // [RULE_05] [RULE_18]
      AR_AUX: ok = int'(w) < TIMERS; // [RULE_08]
      AR_TMR, AR_CNT, AR_TBIT, AR_CBIT: ok = (int'(w) < TIMERS) && !b;
      AR_DAT, AR_FIL: ok = !b; // [RULE_13] [RULE_19]
      AR_LNK: ok = (int'(w) < 1024) && (!b || int'(w) < LINK_BIT_WORDS); // [RULE_16]
      AR_IDX: ok = (int'(w) < 3) && !b;
      AR_CTL: ok = (int'(w) < CTL_WORDS) && !b;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Base of each stored view inside the shared memory
  function automatic logic [14:0] ramBase(input cud_area_type a);
    logic [14:0] base;
    base = AUX_BASE;
    case (a)
      AR_SPC: base = SPC_BASE;
      AR_TMR: base = TMR_BASE;
      AR_CNT: base = CNT_BASE;
      AR_LNK: base = LNK_BASE; // [RULE_17]
      AR_RLK: base = RLK_BASE;
      AR_DAT: base = DAT_BASE;
      AR_FIL: base = FIL_BASE;
      default: base = AUX_BASE;
    endcase
    return base;
  endfunction

  // Two flip-flops on everything that comes from pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modInMeta <= '0;
      modInSync <= '0;
      protMeta <= 1'b0;
      protSync <= 1'b0;
      perMeta <= 1'b0;
      perSync <= 1'b0;
    end else begin
      modInMeta <= modIn;
      modInSync <= modInMeta;
      protMeta <= protectRun;
      protSync <= protMeta;
      perMeta <= perMemPresent;
      perSync <= perMeta;
    end
  end

  // Straps resync through reset, so the clear phase sees them from its first word
  always_ff @(posedge sys_clk) begin
    retMeta <= retainCfg;
    retSync <= retMeta;
  end

  // Effective address; index words themselves are never indexed
  always_comb begin
    effWord = regAddr.word;
    if (regAddr.idxSel != 2'h0 && regAddr.area != AR_IDX) begin
      effWord = regAddr.word + idxReg[regAddr.idxSel - 2'h1][12:0]; // [RULE_20]
    end
  end

  assign w8 = effWord[7:0];
  assign ramAddr = ramBase(regAddr.area) + {2'h0, effWord};
  assign isRam = regAddr.area inside {AR_AUX, AR_SPC, AR_TMR, AR_CNT, AR_DAT, AR_LNK, AR_RLK, AR_FIL};
  assign rdOk = accessOk(regAddr.area, effWord, regAddr.bitMode, 1'b0);

  // Protected data words refuse writes while running protected
  assign wrOk = regWr && state == ST_RUN && accessOk(regAddr.area, effWord, regAddr.bitMode, 1'b1)
    && !(regAddr.area == AR_DAT && protSync && effWord <= DPROT_LAST); // [RULE_15]
  assign procRamWr = wrOk && isRam;
  assign ctlWr = wrOk && regAddr.area == AR_CTL;

  // Current content of the addressed word
  always_comb begin
    curWord = '0;
    case (regAddr.area)
      AR_IN: curWord = inReg[w8];
      AR_OUT, AR_DOUT: curWord = outReg[w8];
      AR_DIN: curWord = modInSync[w8]; // [RULE_06]
      AR_TBIT: curWord = {15'h0, timerBit[effWord[8:0]]}; // [RULE_10]
      AR_CBIT: curWord = {15'h0, counterBit[effWord[8:0]]}; // [RULE_12]
      AR_IDX: curWord = idxReg[effWord[1:0]];
      AR_CTL: begin
        if (effWord >= CTL_ALLOC) begin
          curWord = directOnly[effWord[3:0]*16 +: 16];
        end else if (effWord == CTL_STAT) begin
          curWord = {13'h0, protSync, perSync, state == ST_RUN};
        end
      end
      AR_SPC: begin
        if (effWord == SPW_FAULT) begin
          curWord = faultReg;
        end else if (effWord == SPW_PULSE) begin
          curWord = pulseWord;
        end else if (effWord == SPW_CAL) begin
          curWord = calSec;
        end else begin
          curWord = ram[ramAddr];
        end
      end
      default: curWord = ram[ramAddr];
    endcase
  end

  // Bit writes merge into the word, other bits kept
  always_comb begin
    wrVal = regWrData;
    if (regAddr.bitMode) begin
      wrVal = curWord;
      wrVal[regAddr.bitPos] = regWrData[0]; // [RULE_23] [RULE_22]
    end
  end

  assign rdVal = regAddr.bitMode ? {15'h0, curWord[regAddr.bitPos]} : curWord; // [RULE_05]

  // Read answer stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRd && rdOk) begin
      regRdData <= rdVal;
    end else begin
      regRdData <= '0;
    end
  end

  // Input words change only at batch or direct refresh
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      inReg <= '0;
    end else if (ctlWr && effWord == CTL_BATCH) begin
      for (int i = 0; i < IO_WORDS; i++) begin
        if (!directOnly[i]) begin
          inReg[i] <= modInSync[i]; // [RULE_01] [RULE_21]
        end
      end
    end else if (ctlWr && effWord == CTL_DREF) begin
      inReg[regWrData[7:0]] <= modInSync[regWrData[7:0]]; // [RULE_03]
    end
  end

  // Output words and the module pins they drive
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      outReg <= '0;
      modOut <= '0;
    end else if (ctlWr && effWord == CTL_BATCH) begin
      for (int i = 0; i < IO_WORDS; i++) begin
        if (!directOnly[i]) begin
          modOut[i] <= outReg[i]; // [RULE_04] [RULE_21]
        end
      end
    end else if (wrOk && regAddr.area == AR_OUT) begin
      outReg[w8] <= wrVal;
    end else if (wrOk && regAddr.area == AR_DOUT) begin
      outReg[w8] <= wrVal; // [RULE_07]
      modOut[w8] <= wrVal; // [RULE_07]
    end else if (ctlWr && effWord == CTL_DREF) begin
      modOut[regWrData[7:0]] <= outReg[regWrData[7:0]];
    end
  end

  // Allocation: direct-only modules, one flag per word
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      directOnly <= '0;
    end else if (ctlWr && effWord >= CTL_ALLOC) begin
      directOnly[effWord[3:0]*16 +: 16] <= regWrData; // [RULE_21]
    end
  end

  // Index words
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      idxReg <= '{default: 16'h0};
    end else if (wrOk && regAddr.area == AR_IDX) begin
      idxReg[effWord[1:0]] <= wrVal;
    end
  end

  // Timer run flags and timer and counter result bits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timerRun <= '0;
      timerBit <= '0;
      counterBit <= '0;
    end else if (ctlWr && effWord == CTL_TMR) begin
      timerRun[regWrData[8:0]] <= regWrData[15];
    end else if (wrOk && regAddr.area == AR_TBIT) begin
      timerBit[effWord[8:0]] <= regWrData[0]; // [RULE_10]
    end else if (wrOk && regAddr.area == AR_CBIT) begin
      counterBit[effWord[8:0]] <= regWrData[0]; // [RULE_12]
    end
  end

  // Fault flags: a new fault wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      faultReg <= FAULT_RST;
    end else if (wrOk && regAddr.area == AR_SPC && effWord == SPW_FAULT) begin
      faultReg <= (faultReg & wrVal) | faultIn; // [RULE_09]
    end else begin
      faultReg <= faultReg | faultIn; // [RULE_09]
    end
  end

  // Time base dividers
  assign fastTick = tickCnt == 32'(TICK_CYCLES - 1);
  assign slowTick = fastTick && slowCnt == SLOW_PER_FAST - 4'h1;
  assign secTick = slowTick && secCnt == SEC_PER_SLOW - 4'h1;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tickCnt <= '0;
      slowCnt <= '0;
      secCnt <= '0;
    end else begin
      tickCnt <= fastTick ? 32'h0 : tickCnt + 32'h1;
      if (fastTick) begin
        slowCnt <= slowTick ? 4'h0 : slowCnt + 4'h1;
      end
      if (slowTick) begin
        secCnt <= secTick ? 4'h0 : secCnt + 4'h1;
      end
    end
  end

  // Timing pulse and calendar words kept by hardware
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulseWord <= '0;
      calSec <= '0;
    end else begin
      if (fastTick) begin
        pulseWord[0] <= ~pulseWord[0]; // [RULE_09]
      end
      if (slowTick) begin
        pulseWord[1] <= ~pulseWord[1];
      end
      if (secTick) begin
        pulseWord[2] <= ~pulseWord[2];
        calSec <= calSec + 16'h1; // [RULE_09]
      end
    end
  end

  // Timer sweep; yields to processor writes, so it may stretch a little
  assign sweepStep = sweepBusy && !procRamWr && state == ST_RUN;
  assign tmrCur = ram[TMR_BASE + {6'h0, sweepPtr}];
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sweepBusy <= 1'b0;
      sweepPtr <= '0;
      sweepEnd <= '0;
    end else if (fastTick) begin
      sweepBusy <= 1'b1;
      sweepPtr <= '0;
      sweepEnd <= slowTick ? 9'(TIMERS - 1) : 9'(FAST_TIMERS - 1); // [RULE_11]
    end else if (sweepStep) begin
      sweepPtr <= sweepPtr + 9'h1;
      if (sweepPtr == sweepEnd) begin
        sweepBusy <= 1'b0;
      end
    end
  end

  // Start-up sequence: clear volatile areas, then optional load
  assign clrEn = !((initPtr < SPC_BASE && retSync.retAux)
    || (initPtr >= CNT_BASE && initPtr < LNK_BASE && retSync.retCnt)
    || (initPtr >= DAT_BASE && retSync.retDat)); // [RULE_08] [RULE_12] [RULE_13]
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_CLEAR;
      initPtr <= '0;
      loadPtr <= '0;
      perMemAddr <= '0;
      perMemRd <= 1'b0;
      initDone <= 1'b0;
      loadRdQ <= 1'b0;
      loadAddrQ <= '0;
    end else begin
      // Memory answers a cycle after its strobe, so the capture runs one cycle late
      loadRdQ <= perMemRd;
      loadAddrQ <= perMemAddr;
      case (state)
        ST_CLEAR: begin
          initPtr <= initPtr + 15'h1;
          if (initPtr == FIL_BASE - 15'h1) begin
            state <= perSync ? ST_LOAD : ST_RUN; // [RULE_14]
            initDone <= !perSync;
          end
        end
        ST_LOAD: begin
          if (int'(loadPtr) < LOAD_WORDS) begin
            perMemAddr <= loadPtr[11:0];
            perMemRd <= 1'b1;
            loadPtr <= loadPtr + 13'h1;
          end else begin
            perMemRd <= 1'b0;
            if (!perMemRd) begin
              state <= ST_RUN;
              initDone <= 1'b1;
            end
          end
        end
        ST_RUN: initDone <= 1'b1;
        default: state <= ST_CLEAR;
      endcase
    end
  end

  // Shared word memory; file words are never cleared
  always_ff @(posedge sys_clk) begin
    if (state == ST_CLEAR) begin
      if (clrEn && !rst) begin // Held reset must not wipe a retained word
        ram[initPtr] <= 16'h0; // [RULE_19]
      end
    end else if (state == ST_LOAD) begin
      if (loadRdQ) begin
        ram[DAT_BASE + {3'h0, loadAddrQ}] <= perMemData; // [RULE_14]
      end
    end else if (procRamWr) begin
      ram[ramAddr] <= wrVal; // [RULE_08] [RULE_18]
    end else if (sweepStep && timerRun[sweepPtr] && tmrCur != 16'hffff) begin
      ram[TMR_BASE + {6'h0, sweepPtr}] <= tmrCur + 16'h1; // [RULE_10]
    end
  end
endmodule

/* design/cud_pkg.sv */
// Constants, address layout and carrier types for the user data memory.
// Assumes a 40 MHz sys_clk and one processor master on the register port.
// Function
// [RULE_01] Batch refresh copies every refreshed input module into its input words 000-255.
// [RULE_02] Input words and bits stay constant during a scan, except direct refresh.
// [RULE_03] Direct refresh instruction reads the input module now and updates its input word.
// [RULE_04] Batch refresh sends every refreshed output word 000-255 to its output module.
// [RULE_05] Each I/O bit address aliases one bit of its word, 4096 points.
// [RULE_06] Direct input view reads the module live; stored input word stays unchanged.
// [RULE_07] Direct output write stores into the output word, then sends the whole word.
// [RULE_08] 512 general words with bit access; may be retained over reset.
// [RULE_09] Device sets fault flags, updates pulse and calendar words, holds user control words.
// [RULE_10] Active timer words count up; timer bit holds the timer result.
// [RULE_11] Timers 000-063 count 0.01 s units, timers 064-511 count 0.1 s units.
// [RULE_12] Counter words hold counts, counter bits hold outputs; counters may be retained.
// [RULE_13] 8192 data words like general words but without bit access; may be retained.
// [RULE_14] With a peripheral memory present, data words 0000-4095 load at start.
// [RULE_15] Protected run state blocks every write to data words 0000-4095.
// [RULE_16] 1024 link words; only the first 512 allow bit access.
// [RULE_17] Unassigned link words behave as ordinary storage.
// [RULE_18] 256 remote link words with 4096 bits, ordinary storage when unused.
// [RULE_19] 8192 file words without bit access, always kept over reset.
// [RULE_20] Indexed operand adds one of three index words; index words not indexable.
// [RULE_21] Modules map to whole words; direct-only modules skip batch refresh.
// [RULE_22] Every word is 16 bits; bit address is word plus position 0 to F.
// [RULE_23] A single bit write changes only that bit of its word.
package cud_pkg;
  localparam int WORD_W = 16;
  localparam int IO_WORDS = 256;
  localparam int TIMERS = 512;
  localparam int FAST_TIMERS = 64;
  localparam int LINK_BIT_WORDS = 512;
  localparam int RAM_WORDS = 20480;
  localparam int LOAD_WORDS = 4096;
  localparam logic [12:0] DPROT_LAST = 13'h0fff;
  // Storage bases inside the shared word memory
  localparam logic [14:0] AUX_BASE = 15'h0000;
  localparam logic [14:0] SPC_BASE = 15'h0200;
  localparam logic [14:0] TMR_BASE = 15'h0300;
  localparam logic [14:0] CNT_BASE = 15'h0500;
  localparam logic [14:0] LNK_BASE = 15'h0700;
  localparam logic [14:0] RLK_BASE = 15'h0b00;
  localparam logic [14:0] DAT_BASE = 15'h1000;
  localparam logic [14:0] FIL_BASE = 15'h3000;
  // Control word offsets
  localparam logic [12:0] CTL_BATCH = 13'h0000;
  localparam logic [12:0] CTL_DREF = 13'h0001;
  localparam logic [12:0] CTL_TMR = 13'h0002;
  localparam logic [12:0] CTL_STAT = 13'h0003;
  localparam logic [12:0] CTL_ALLOC = 13'h0010;
  localparam int CTL_WORDS = 32;
  // Hardware-owned special words
  localparam logic [12:0] SPW_FAULT = 13'h0001;
  localparam logic [12:0] SPW_PULSE = 13'h0004;
  localparam logic [12:0] SPW_CAL = 13'h0007;
  localparam logic [15:0] FAULT_RST = 16'h0000;
  // Time base: 10 ms fast tick, 100 ms slow tick, 1 s calendar tick
  localparam int CLK_HZ = 40000000;
  localparam int FAST_TICK_US = 10000;
  localparam int FAST_TICK_CYC = CLK_HZ / 1000000 * FAST_TICK_US;
  localparam logic [3:0] SLOW_PER_FAST = 4'ha;
  localparam logic [3:0] SEC_PER_SLOW = 4'ha;

  typedef enum logic [3:0] {
    AR_IN, AR_OUT, AR_DIN, AR_DOUT, AR_AUX, AR_SPC, AR_TMR, AR_CNT,
    AR_DAT, AR_LNK, AR_RLK, AR_FIL, AR_TBIT, AR_CBIT, AR_IDX, AR_CTL
  } cud_area_type;

  typedef struct packed {
    cud_area_type area;
    logic [1:0] idxSel;
    logic bitMode;
    logic [3:0] bitPos;
    logic [12:0] word;
  } cud_addr_type;

  typedef struct packed {
    logic retAux;
    logic retCnt;
    logic retDat;
  } cud_retain_type;

  typedef enum logic [1:0] {ST_CLEAR, ST_LOAD, ST_RUN} cud_state_type;
endpackage

/* testbench/cud_user_data_props.sv */
// Port checks for the user data memory, attached to cud_user_data by bind.
// Assumes one sys_clk domain and a synchronous active-high rst.
`timescale 1ns/100ps
module cud_user_data_props
  import cud_pkg::*;
#(
  parameter int TICK_CYCLES = FAST_TICK_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire cud_pkg::cud_addr_type regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdData,
  // Pins and state
  input wire logic [IO_WORDS-1:0][15:0] modOut,
  input wire logic [11:0] perMemAddr,
  input wire logic perMemRd,
  input wire logic initDone
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic ioWr;
  logic doutWr;
  // Writes that may move the output pins
  assign ioWr = regWr && (regAddr.area == AR_DOUT || (regAddr.area == AR_CTL && regAddr.word < 13'h0002));
  assign doutWr = regWr && initDone && regAddr.area == AR_DOUT && !regAddr.bitMode && regAddr.idxSel == 2'h0
    && regAddr.word < 13'h0100;

  a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data present without a read");
  // Reset entry clears the pins, so the cycle after rst is excused
  a_out_hold: assert property (!$past(rst) && !$past(ioWr) |-> $stable(modOut))
    else $error("output pins moved without a refresh");
  a_dout_word: assert property (doutWr |=> modOut[$past(regAddr.word[7:0])] == $past(regWrData))
    else $error("direct output word not sent");
  a_dout_other: assert property (doutWr |=> modOut[~$past(regAddr.word[7:0])] == $past(modOut[~regAddr.word[7:0]]))
    else $error("direct output disturbed another word");
  a_load_start: assert property ($rose(perMemRd) |-> perMemAddr == 12'h000 ##0 perMemRd [*8])
    else $error("initial load not a burst from zero");
  a_load_step: assert property (perMemRd && $past(perMemRd) |-> perMemAddr == $past(perMemAddr) + 12'h001)
    else $error("initial load address skipped");
  a_load_done: assert property (initDone |-> !perMemRd)
    else $error("load read while running");
  a_init_level: assert property (initDone |=> initDone)
    else $error("start-up flag dropped");
  a_init_late: assert property ($fell(rst) |-> !initDone [*8])
    else $error("start-up flag too early");
  // Main scenarios
  c_dout: cover property (doutWr);
  c_batch: cover property (initDone && regWr && regAddr.area == AR_CTL && regAddr.word == 13'h0000);
  c_load: cover property ($rose(perMemRd));
endmodule
bind cud_user_data cud_user_data_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
  .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .modOut(modOut), .perMemAddr(perMemAddr), .perMemRd(perMemRd), .initDone(initDone));

/* testbench/cud_io_model.sv */
// Input modules and peripheral memory standing at the far side of the block.
// Assumes the bench sets the input pattern; memory answers on sys_clk.
`timescale 1ns/100ps
module cud_io_model (
  // Clock and pattern
  input wire logic sys_clk,
  input wire logic [7:0] inSeed,
  // Input module pins
  output logic [255:0][15:0] modIn,
  // Peripheral memory
  input wire logic [11:0] perMemAddr,
  input wire logic perMemRd,
  output logic [15:0] perMemData
);
  // One whole word per module: its number, then the pattern
  always_comb begin
    for (int k = 0; k < 256; k++) begin
      modIn[k] = {8'(k), inSeed};
    end
  end
  // Image is 4'ha then address; idle cycles show the inverse, never a stale word
  always_ff @(posedge sys_clk) begin
    if (perMemRd) begin
      perMemData <= {4'ha, perMemAddr};
    end else begin
      perMemData <= ~{4'ha, perMemAddr};
    end
  end
endmodule

/* testbench/cud_user_data_bench.sv */
// Self-checking bench for the user data memory and its I/O refresh.
// Assumes cud_io_model on the pins and the bound port checker.
`timescale 1ns/100ps
module cud_user_data_bench;
  import cud_pkg::*;
  localparam int TICK = 1024;
  localparam int LIMIT = 60000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  cud_addr_type regAddr = '0;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdData;
  logic [IO_WORDS-1:0][15:0] modIn;
  logic [IO_WORDS-1:0][15:0] modOut;
  logic [15:0] perMemData;
  logic [11:0] perMemAddr;
  logic perMemRd;
  logic protectRun = 1'b0;
  logic perPresent = 1'b1;
  cud_retain_type retain = '0;
  logic [15:0] faultIn = 16'h0000;
  logic initDone;
  logic [7:0] inSeed = 8'h11;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;

  cud_user_data #(.TICK_CYCLES(TICK)) i_dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .modIn(modIn), .modOut(modOut),
    .perMemPresent(perPresent), .perMemData(perMemData), .perMemAddr(perMemAddr), .perMemRd(perMemRd),
    .retainCfg(retain), .protectRun(protectRun), .faultIn(faultIn), .initDone(initDone));
  cud_io_model i_io (.sys_clk(sys_clk), .inSeed(inSeed), .modIn(modIn), .perMemAddr(perMemAddr),
    .perMemRd(perMemRd), .perMemData(perMemData));

  // 40 MHz clock and a hang guard
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      complete_run;
    end
  end

  function automatic cud_addr_type adr(cud_area_type a, int w, logic b = 1'b0, int p = 0, int x = 0);
    adr = '{area: a, idxSel: 2'(x), bitMode: b, bitPos: 4'(p), word: 13'(w)};
  endfunction
  // One-cycle strobes; a write settles before the caller looks at pins
  task automatic wr(cud_addr_type a, logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(cud_addr_type a, output logic [15:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(string what, cud_addr_type a, logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(what, v, exp);
  endtask
  // Pins are synchronised, so give them time to land
  task automatic seed(logic [7:0] v);
    @(posedge sys_clk);
    inSeed <= v;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic t_start;
    int n;
    n = 0;
    while (initDone !== 1'b1 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("initDone", {15'h0, initDone}, 16'h0001);
    rchk("loaded D0005", adr(AR_DAT, 5), 16'ha005);
    rchk("loaded D4095", adr(AR_DAT, 4095), 16'hafff);
    rchk("D4096 cleared", adr(AR_DAT, 4096), 16'h0000);
  endtask
  task automatic t_batch;
    wr(adr(AR_CTL, 0), 16'h0000);
    rchk("batch IN7", adr(AR_IN, 7), 16'h0711);
    rchk("IN7 bit4", adr(AR_IN, 7, 1'b1, 4), 16'h0001);
    rchk("IN7 bit1", adr(AR_IN, 7, 1'b1, 1), 16'h0000);
    seed(8'h22);
    rchk("IN7 held", adr(AR_IN, 7), 16'h0711);
    rchk("live DIN7", adr(AR_DIN, 7), 16'h0722);
    rchk("live DIN7 bit5", adr(AR_DIN, 7, 1'b1, 5), 16'h0001);
    rchk("IN7 after DIN", adr(AR_IN, 7), 16'h0711);
    wr(adr(AR_CTL, 1), 16'h0007);
    rchk("refreshed IN7", adr(AR_IN, 7), 16'h0722);
    rchk("IN8 untouched", adr(AR_IN, 8), 16'h0811);
    wr(adr(AR_CTL, 16), 16'h0080);
    seed(8'h33);
    wr(adr(AR_CTL, 0), 16'h0000);
    rchk("direct-only IN7", adr(AR_IN, 7), 16'h0722);
    rchk("batch IN8", adr(AR_IN, 8), 16'h0833);
    wr(adr(AR_CTL, 16), 16'h0000);
  endtask
  task automatic t_output;
    wr(adr(AR_OUT, 3), 16'h1234);
    wr(adr(AR_CTL, 0), 16'h0000);
    chk("modOut3 batch", modOut[3], 16'h1234);
    wr(adr(AR_OUT, 3), 16'h5678);
    chk("modOut3 held", modOut[3], 16'h1234);
    wr(adr(AR_CTL, 0), 16'h0000);
    chk("modOut3 next batch", modOut[3], 16'h5678);
    wr(adr(AR_DOUT, 5), 16'habcd);
    chk("direct out5", modOut[5], 16'habcd);
    rchk("OUT5 stored", adr(AR_OUT, 5), 16'habcd);
    wr(adr(AR_DOUT, 5, 1'b1, 0), 16'h0000);
    chk("direct bit out5", modOut[5], 16'habcc);
  endtask
  task automatic t_areas;
    wr(adr(AR_AUX, 9), 16'h00ff);
    wr(adr(AR_AUX, 9, 1'b1, 4), 16'h0000);
    rchk("AUX9 bit clear", adr(AR_AUX, 9), 16'h00ef);
    wr(adr(AR_AUX, 9, 1'b1, 15), 16'h0001);
    rchk("AUX9 bit set", adr(AR_AUX, 9), 16'h80ef);
    wr(adr(AR_AUX, 600), 16'h1111);
    rchk("AUX600 refused", adr(AR_AUX, 600), 16'h0000);
    wr(adr(AR_DAT, 5000), 16'h5555);
    rchk("D5000 bit refused", adr(AR_DAT, 5000, 1'b1, 0), 16'h0000);
    rchk("D5000", adr(AR_DAT, 5000), 16'h5555);
    wr(adr(AR_LNK, 600), 16'hffff);
    rchk("W0600 bit refused", adr(AR_LNK, 600, 1'b1, 3), 16'h0000);
    rchk("W0600", adr(AR_LNK, 600), 16'hffff);
    wr(adr(AR_LNK, 511, 1'b1, 15), 16'h0001);
    rchk("W0511", adr(AR_LNK, 511), 16'h8000);
    wr(adr(AR_RLK, 255, 1'b1, 15), 16'h0001);
    rchk("remote link 255", adr(AR_RLK, 255), 16'h8000);
    wr(adr(AR_FIL, 8191), 16'h2468);
    rchk("F8191", adr(AR_FIL, 8191), 16'h2468);
    rchk("F8191 bit refused", adr(AR_FIL, 8191, 1'b1, 3), 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wr(adr(AR_IDX, i), 16'h0003);
    end
    rchk("indexed AUX6", adr(AR_AUX, 6, 1'b0, 0, 2), 16'h80ef);
    wr(adr(AR_CNT, 7), 16'h0042);
    rchk("C007", adr(AR_CNT, 7), 16'h0042);
    wr(adr(AR_CBIT, 7), 16'h0001);
    rchk("counter bit 7", adr(AR_CBIT, 7), 16'h0001);
    wr(adr(AR_TBIT, 5), 16'h0001);
    rchk("timer bit 5", adr(AR_TBIT, 5), 16'h0001);
  endtask
  task automatic t_protect;
    @(posedge sys_clk);
    protectRun <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wr(adr(AR_DAT, 10), 16'h5555);
    rchk("protected D0010", adr(AR_DAT, 10), 16'ha00a);
    wr(adr(AR_DAT, 4096), 16'h5555);
    rchk("open D4096", adr(AR_DAT, 4096), 16'h5555);
    @(posedge sys_clk);
    protectRun <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(adr(AR_DAT, 10), 16'h7777);
    rchk("unprotected D0010", adr(AR_DAT, 10), 16'h7777);
  endtask
  // Reads stand exactly ten fast ticks apart, so tick phase cancels out
  task automatic t_timer;
    logic [15:0] a0, b0, a1, b1;
    wr(adr(AR_CTL, 2), 16'h8000);
    wr(adr(AR_CTL, 2), 16'h8040);
    rd(adr(AR_TMR, 0), a0);
    rd(adr(AR_TMR, 64), b0);
    repeat (TICK * 10 - 4) @(posedge sys_clk);
    rd(adr(AR_TMR, 0), a1);
    rd(adr(AR_TMR, 64), b1);
    chk("fast timer step", a1 - a0, 16'h000a);
    chk("slow timer step", b1 - b0, 16'h0001);
    @(posedge sys_clk);
    faultIn <= 16'h0008;
    @(posedge sys_clk);
    faultIn <= 16'h0000;
    rchk("fault flag", adr(AR_SPC, 1), 16'h0008);
    wr(adr(AR_SPC, 1), 16'h0000);
    rchk("fault cleared", adr(AR_SPC, 1), 16'h0000);
  endtask
  // Second start: no peripheral memory, only general words strapped for retention
  task automatic t_restart;
    @(posedge sys_clk);
    rst <= 1'b1;
    perPresent <= 1'b0;
    retain <= '{retAux: 1'b1, retCnt: 1'b0, retDat: 1'b0};
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    wait (initDone === 1'b1);
    rchk("retained AUX9", adr(AR_AUX, 9), 16'h80ef);
    rchk("cleared C007", adr(AR_CNT, 7), 16'h0000);
    rchk("unloaded D0010", adr(AR_DAT, 10), 16'h0000);
    rchk("kept F8191", adr(AR_FIL, 8191), 16'h2468);
  endtask

  task automatic complete_run;
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_start;
    t_batch;
    t_output;
    t_areas;
    t_protect;
    t_timer;
    t_restart;
    complete_run;
  end
endmodule
